// ===== rtc_relay_ctrl.sv
// Relay and indicator control from a measured value, with AXI4-Lite configuration.
// Assumes value, peak, range fault and link events arrive on mclk from the same domain.
`timescale 1ns/1ps
module rtc_relay_ctrl #(
  parameter int TENTH_TICK = rtc_pkg::TENTH_CYCLES
) (
  input  wire logic                              mclk,
  input  wire logic                              srst,
  input  wire logic [rtc_pkg::AXI_AW-1:0]        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [rtc_pkg::AXI_AW-1:0]        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic signed [rtc_pkg::VAL_W-1:0]  measValue,
  input  wire logic signed [rtc_pkg::VAL_W-1:0]  peakValue,
  input  wire logic                              peakActive,
  input  wire logic                              rangeFault,
  input  wire logic                              linkRxPulse,
  input  wire logic                              busCmdValid,
  input  wire logic                              busCmdOn,
  output logic                                   relayOut,
  output logic                                   ledOut
);
  import rtc_pkg::*;

  typedef struct packed {
    logic                    awReady;
    logic                    wReady;
    logic                    awHeld;
    logic                    wHeld;
    logic [AXI_AW-1:0]       awAddr;
    logic [31:0]             wData;
    logic [3:0]              wStrb;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    arReady;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
    logic [31:0]             ctrl;
    logic signed [VAL_W-1:0] thrOne;
    logic signed [VAL_W-1:0] thrTwo;
    logic [9:0]              hysteresis_half_width;
    logic [9:0]              onDly;
    logic [9:0]              offDly;
    logic [15:0]             linkTo;
    rtc_relay_type           relay;
    logic                    pending;
    logic [9:0]              dlyCnt;
    logic [31:0]             tickCnt;
    logic [5:0]              minCnt;
    logic [15:0]             linkCnt;
    logic                    crit;
    logic                    relayQ;
    logic                    ledQ;
  } rtc_state_type;

  rtc_state_type st_r;
  rtc_state_type st_nxt;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic signed [VAL_W-1:0] clampThr(input logic [31:0] w);
    logic signed [VAL_W-1:0] v;
    v = w[VAL_W-1:0];
    if (v < THR_MIN) begin
      v = THR_MIN;
    end else if (v > THR_MAX) begin
      v = THR_MAX;
    end
    return v;
  endfunction

  function automatic logic [9:0] clampTen(input logic [31:0] w, input logic [9:0] lim);
    logic [9:0] v;
    v = (w > {22'h0, lim}) ? lim : w[9:0];
    return v;
  endfunction

  logic [2:0]                mode;
  logic [1:0]                action;
  logic signed [VAL_W:0]     cmpVal;
  logic signed [VAL_W:0]     loThr;
  logic signed [VAL_W:0]     hiThr;
  logic signed [VAL_W:0]     hExt;
  logic                      wantOn;
  logic                      wantOff;
  logic                      tenthTick;
  logic                      unitTick;
  logic                      isOn;
  logic                      critNow;
  logic                      wrFire;
  logic [31:0]               wrVal;
  logic [31:0]               rdVal;
  logic                      rdHit;
  logic                      wrHit;
  logic [9:0]                dlyNeed;

  always_comb begin
    st_nxt = st_r;
    mode   = st_r.ctrl[CTL_MODE_LSB +: 3];
    action = st_r.ctrl[CTL_ACT_LSB +: 2];
    isOn   = (st_r.relay == RLY_ON);
    // Comparison source: held peak only while peak detection runs
    // source select
    cmpVal = (st_r.ctrl[CTL_PEAK_SEL] && peakActive) ? {peakValue[VAL_W-1], peakValue}
                                                     : {measValue[VAL_W-1], measValue};
    hExt   = $signed({7'h0, st_r.hysteresis_half_width});
    loThr  = {st_r.thrOne[VAL_W-1], st_r.thrOne};
    hiThr  = loThr;
    if (mode == MODE_INSIDE || mode == MODE_OUTSIDE) begin
      if (st_r.thrTwo < st_r.thrOne) begin
        loThr = {st_r.thrTwo[VAL_W-1], st_r.thrTwo};
      end else begin
        hiThr = {st_r.thrTwo[VAL_W-1], st_r.thrTwo};
      end
    end
    wantOn  = 1'b0;
    wantOff = 1'b0;
    case (mode)
      MODE_NORMAL: begin
        wantOn  = cmpVal > loThr + hExt;
        wantOff = cmpVal < loThr - hExt;
      end
      MODE_INVERTED: begin
        wantOff = cmpVal > loThr + hExt;
        wantOn  = cmpVal < loThr - hExt;
      end
      MODE_INSIDE: begin
        wantOn  = (cmpVal > loThr + hExt) && (cmpVal < hiThr - hExt);
        wantOff = (cmpVal < loThr - hExt) || (cmpVal > hiThr + hExt);
      end
      MODE_OUTSIDE: begin
        wantOn  = (cmpVal > hiThr + hExt) || (cmpVal < loThr - hExt);
        wantOff = (cmpVal > loThr + hExt) && (cmpVal < hiThr - hExt);
      end
      default: begin
        wantOn  = 1'b0;
        wantOff = 1'b0;
      end
    endcase

    // Tenth-of-second prescaler, optionally divided to tenths of a minute
    tenthTick = (st_r.tickCnt == 32'(TENTH_TICK - 1));
    st_nxt.tickCnt = tenthTick ? 32'h0 : st_r.tickCnt + 32'h1;
    unitTick = tenthTick;
    if (st_r.ctrl[CTL_MINUTES]) begin
      unitTick = tenthTick && (st_r.minCnt == TENTHS_PER_MIN_UNIT);
      if (tenthTick) begin
        st_nxt.minCnt = (st_r.minCnt == TENTHS_PER_MIN_UNIT) ? 6'h0 : st_r.minCnt + 6'h1;
      end
    end

    if (linkRxPulse || busCmdValid) begin
      st_nxt.linkCnt = 16'h0;
    end else if (tenthTick && st_r.linkCnt != 16'hffff) begin
      st_nxt.linkCnt = st_r.linkCnt + 16'h1;
    end
    critNow = (mode == MODE_BUS) ? (st_r.linkTo != 16'h0 && st_r.linkCnt > st_r.linkTo)
                                 : rangeFault;
    st_nxt.crit = critNow;

    dlyNeed = isOn ? st_r.offDly : st_r.onDly;
    st_nxt.pending = 1'b0;
    st_nxt.dlyCnt  = 10'h0;
    if (critNow) begin
      if (action == ACT_FORCE_ON) begin
        st_nxt.relay = RLY_ON;
      end else if (action == ACT_FORCE_OFF) begin
        st_nxt.relay = RLY_OFF;
      end
    end else if (mode == MODE_INACTIVE) begin
      st_nxt.relay = RLY_OFF;
    end else if (mode == MODE_BUS) begin
      if (busCmdValid) begin
        st_nxt.relay = busCmdOn ? RLY_ON : RLY_OFF;
      end
    end else if ((wantOn && !isOn) || (wantOff && isOn)) begin
      if (st_r.dlyCnt >= dlyNeed) begin
        st_nxt.relay = isOn ? RLY_OFF : RLY_ON;
      end else begin
        st_nxt.pending = 1'b1;
        st_nxt.dlyCnt  = unitTick ? st_r.dlyCnt + 10'h1 : st_r.dlyCnt;
      end
    end
    st_nxt.ledQ   = (st_nxt.relay == RLY_ON);
    st_nxt.relayQ = (st_nxt.relay == RLY_ON) && st_r.ctrl[CTL_FITTED];

    // AXI4-Lite write: address and data in either order, response after both
    if (s_axi_awvalid && st_r.awReady) begin
      st_nxt.awHeld  = 1'b1;
      st_nxt.awAddr  = s_axi_awaddr;
      st_nxt.awReady = 1'b0;
    end
    if (s_axi_wvalid && st_r.wReady) begin
      st_nxt.wHeld  = 1'b1;
      st_nxt.wData  = s_axi_wdata;
      st_nxt.wStrb  = s_axi_wstrb;
      st_nxt.wReady = 1'b0;
    end
    wrFire = st_r.awHeld && st_r.wHeld && !st_r.bValid;
    wrHit  = 1'b0;
    wrVal  = 32'h0;
    if (wrFire) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bValid = 1'b1;
      wrHit = 1'b1;
      case (st_r.awAddr)
        OFS_CTRL: begin
          st_nxt.ctrl = mergeStrb(st_r.ctrl, st_r.wData, st_r.wStrb);
        end
        OFS_THR_ONE: begin
          wrVal = mergeStrb({{16{st_r.thrOne[VAL_W-1]}}, st_r.thrOne}, st_r.wData, st_r.wStrb);
          st_nxt.thrOne = clampThr(wrVal);
        end
        OFS_THR_TWO: begin
          wrVal = mergeStrb({{16{st_r.thrTwo[VAL_W-1]}}, st_r.thrTwo}, st_r.wData, st_r.wStrb);
          st_nxt.thrTwo = clampThr(wrVal);
        end
        OFS_HYSTERESIS_HALF_WIDTH: begin
          st_nxt.hysteresis_half_width = clampTen(mergeStrb({22'h0, st_r.hysteresis_half_width}, st_r.wData, st_r.wStrb), HYSTERESIS_HALF_WIDTH_MAX);
        end
        OFS_ON_DLY: begin
          st_nxt.onDly = clampTen(mergeStrb({22'h0, st_r.onDly}, st_r.wData, st_r.wStrb), DLY_MAX);
        end
        OFS_OFF_DLY: begin
          st_nxt.offDly = clampTen(mergeStrb({22'h0, st_r.offDly}, st_r.wData, st_r.wStrb),
                                   DLY_MAX);
        end
        OFS_LINK_TO: begin
          wrVal = mergeStrb({16'h0, st_r.linkTo}, st_r.wData, st_r.wStrb);
          st_nxt.linkTo = wrVal[15:0];
        end
        default: begin
          wrHit = 1'b0;
        end
      endcase
      st_nxt.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid  = 1'b0;
      st_nxt.awReady = 1'b1;
      st_nxt.wReady  = 1'b1;
    end

    // AXI4-Lite read
    rdHit = 1'b1;
    case (s_axi_araddr)
      OFS_CTRL:    rdVal = st_r.ctrl;
      OFS_THR_ONE: rdVal = {{16{st_r.thrOne[VAL_W-1]}}, st_r.thrOne};
      OFS_THR_TWO: rdVal = {{16{st_r.thrTwo[VAL_W-1]}}, st_r.thrTwo};
      OFS_HYSTERESIS_HALF_WIDTH:    rdVal = {22'h0, st_r.hysteresis_half_width};
      OFS_ON_DLY:  rdVal = {22'h0, st_r.onDly};
      OFS_OFF_DLY: rdVal = {22'h0, st_r.offDly};
      OFS_LINK_TO: rdVal = {16'h0, st_r.linkTo};
      OFS_STATUS:  rdVal = {29'h0, st_r.pending, st_r.crit, isOn};
      default: begin
        rdVal = 32'h0;
        rdHit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && st_r.arReady) begin
      st_nxt.arReady = 1'b0;
      st_nxt.rValid  = 1'b1;
      st_nxt.rData   = rdVal;
      st_nxt.rResp   = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid  = 1'b0;
      st_nxt.arReady = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r         <= '0;
      st_r.awReady <= 1'b1;
      st_r.wReady  <= 1'b1;
      st_r.arReady <= 1'b1;
      st_r.ctrl    <= CTRL_RST;
      st_r.relay   <= RLY_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awReady;
  assign s_axi_wready  = st_r.wReady;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = st_r.arReady;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign relayOut      = st_r.relayQ;
  assign ledOut        = st_r.ledQ;

  led_follows_a: assert property (@(posedge mclk) disable iff (srst)
    ledOut == (st_r.relay == RLY_ON)) else $error("indicator differs from relay");
  unfitted_off_a: assert property (@(posedge mclk) disable iff (srst)
    !st_r.ctrl[CTL_FITTED] |=> !relayOut) else $error("unfitted relay driven");
  inactive_off_a: assert property (@(posedge mclk) disable iff (srst)
    mode == MODE_INACTIVE && !critNow |=> st_r.relay == RLY_OFF) else $error("inactive on");
  force_on_a: assert property (@(posedge mclk) disable iff (srst)
    critNow && action == ACT_FORCE_ON |=> st_r.relay == RLY_ON) else $error("no force on");
  force_off_a: assert property (@(posedge mclk) disable iff (srst)
    critNow && action == ACT_FORCE_OFF |=> st_r.relay == RLY_OFF) else $error("no force off");
  hold_state_a: assert property (@(posedge mclk) disable iff (srst)
    critNow && action == ACT_HOLD |=> $stable(st_r.relay)) else $error("hold changed");
  zero_delay_a: assert property (@(posedge mclk) disable iff (srst)
    mode == MODE_NORMAL && !critNow && wantOn && !isOn && st_r.onDly == 10'h0
    |=> st_r.relay == RLY_ON) else $error("zero delay not immediate");
  no_early_on_a: assert property (@(posedge mclk) disable iff (srst)
    $rose(st_r.relay == RLY_ON) && !$past(critNow) && $past(mode) != MODE_BUS
    |-> $past(st_r.dlyCnt) >= $past(st_r.onDly)) else $error("switched on early");
  restart_a: assert property (@(posedge mclk) disable iff (srst)
    st_r.pending && !st_nxt.pending |=> st_r.dlyCnt == 10'h0) else $error("timer kept");
  bus_ignores_a: assert property (@(posedge mclk) disable iff (srst)
    mode == MODE_BUS && !critNow && !busCmdValid |=> $stable(st_r.relay))
    else $error("bus mode moved by input");
  hysteresis_half_width_limit_a: assert property (@(posedge mclk) disable iff (srst)
    st_r.hysteresis_half_width <= HYSTERESIS_HALF_WIDTH_MAX && st_r.thrOne >= THR_MIN && st_r.thrOne <= THR_MAX)
    else $error("setting out of range");
  link_crit_a: assert property (@(posedge mclk) disable iff (srst)
    mode == MODE_BUS && st_r.linkTo != 16'h0 && st_r.linkCnt > st_r.linkTo |=> st_r.crit)
    else $error("link timeout missed");

endmodule

// ===== rtc_pkg.sv
// Package for the relay threshold control block: register map, field layout, encodings, timing.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register bus.
package rtc_pkg;

  localparam int          AXI_AW        = 8;
  localparam int          VAL_W         = 16;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_THR_ONE   = 8'h04;
  localparam logic [7:0]  OFS_THR_TWO   = 8'h08;
  localparam logic [7:0]  OFS_HYSTERESIS_HALF_WIDTH      = 8'h0c;
  localparam logic [7:0]  OFS_ON_DLY    = 8'h10;
  localparam logic [7:0]  OFS_OFF_DLY   = 8'h14;
  localparam logic [7:0]  OFS_LINK_TO   = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1c;

  // Control register fields
  localparam int          CTL_MODE_LSB  = 0;
  localparam int          CTL_ACT_LSB   = 4;
  localparam int          CTL_MINUTES   = 8;
  localparam int          CTL_PEAK_SEL  = 9;
  localparam int          CTL_FITTED    = 10;

  // Status register fields
  localparam int          STS_RELAY     = 0;
  localparam int          STS_CRIT      = 1;
  localparam int          STS_PEND      = 2;

  localparam logic [2:0]  MODE_INACTIVE = 3'h0;
  localparam logic [2:0]  MODE_NORMAL   = 3'h1;
  localparam logic [2:0]  MODE_INVERTED = 3'h2;
  localparam logic [2:0]  MODE_INSIDE   = 3'h3;
  localparam logic [2:0]  MODE_OUTSIDE  = 3'h4;
  localparam logic [2:0]  MODE_BUS      = 3'h5;

  localparam logic [1:0]  ACT_HOLD      = 2'h0;
  localparam logic [1:0]  ACT_FORCE_ON  = 2'h1;
  localparam logic [1:0]  ACT_FORCE_OFF = 2'h2;

  localparam logic signed [VAL_W-1:0] THR_MIN  = 16'shfc19;
  localparam logic signed [VAL_W-1:0] THR_MAX  = 16'sh270f;
  localparam logic [9:0]  HYSTERESIS_HALF_WIDTH_MAX      = 10'h3e7;
  localparam logic [9:0]  DLY_MAX       = 10'h3e7;

  localparam logic [31:0] CTRL_RST      = 32'h0000_0400;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Time base: delays count in tenths of a second or tenths of a minute
  localparam int          CLK_MHZ       = 200;
  localparam int          TENTH_MS      = 100;
  localparam int          TENTH_CYCLES  = TENTH_MS * 1000 * CLK_MHZ;
  localparam logic [5:0]  TENTHS_PER_MIN_UNIT = 6'h3b;

  typedef enum logic [1:0] {
    RLY_OFF = 2'b01,
    RLY_ON  = 2'b10
  } rtc_relay_type;

endpackage

// ===== rtc_meas_source.sv
// Model of the measurement source and link command handler facing the relay block.
// Assumes the bench calls its tasks from one process; all changes land just after mclk rises.
`timescale 1ns/1ps
module rtc_meas_source (
  input  wire logic                       mclk,
  output logic signed [rtc_pkg::VAL_W-1:0] measValue,
  output logic signed [rtc_pkg::VAL_W-1:0] peakValue,
  output logic                             peakActive,
  output logic                             rangeFault,
  output logic                             linkRxPulse,
  output logic                             busCmdValid,
  output logic                             busCmdOn
);
  import rtc_pkg::*;

  initial begin
    measValue   = '0;
    peakValue   = '0;
    peakActive  = 1'b0;
    rangeFault  = 1'b0;
    linkRxPulse = 1'b0;
    busCmdValid = 1'b0;
    busCmdOn    = 1'b0;
  end

  task automatic setValue(input logic signed [VAL_W-1:0] v);
    @(posedge mclk);
    measValue <= v;
  endtask

  task automatic setPeak(input logic act, input logic signed [VAL_W-1:0] v);
    @(posedge mclk);
    peakActive <= act;
    peakValue  <= v;
  endtask

  task automatic setFault(input logic f);
    @(posedge mclk);
    rangeFault <= f;
  endtask

  // Command frame; the state line shows the inverted command once the frame is over
  task automatic sendCmd(input logic on);
    @(posedge mclk);
    busCmdValid <= 1'b1;
    busCmdOn    <= on;
    linkRxPulse <= 1'b1;
    @(posedge mclk);
    busCmdValid <= 1'b0;
    busCmdOn    <= ~on;
    linkRxPulse <= 1'b0;
  endtask
endmodule

// ===== rtc_tb.sv
// Self-checking bench for the relay threshold block: registers over AXI4-Lite, modes, delays.
// Assumes the partner model in rtc_meas_source.sv and a shortened tenth-second tick.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  import rtc_pkg::*;
  logic        mclk, srst, relayOut, ledOut, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  logic signed [VAL_W-1:0] measValue, peakValue;
  logic        peakActive, rangeFault, linkRxPulse, busCmdValid, busCmdOn;
  int          failures = 0;
  int          compares = 0;

  rtc_relay_ctrl #(.TENTH_TICK(4)) dut_u (.mclk(mclk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .measValue(measValue), .peakValue(peakValue), .peakActive(peakActive),
    .rangeFault(rangeFault), .linkRxPulse(linkRxPulse), .busCmdValid(busCmdValid),
    .busCmdOn(busCmdOn), .relayOut(relayOut), .ledOut(ledOut));

  rtc_meas_source src_u (.mclk(mclk), .measValue(measValue), .peakValue(peakValue),
    .peakActive(peakActive), .rangeFault(rangeFault), .linkRxPulse(linkRxPulse),
    .busCmdValid(busCmdValid), .busCmdOn(busCmdOn));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      rs = bresp;
      n++;
      if (bvalid || n > 50) break;
    end
    bready <= 1'b0;
    if (n > 50) failures++;
  endtask

  task automatic axiRead(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      rd = rdata;
      rs = rresp;
      n++;
      if (rvalid || n > 50) break;
    end
    rready <= 1'b0;
    if (n > 50) failures++;
  endtask

  task automatic ctrl(input logic [2:0] m, input logic [1:0] act, input logic [1:0] minPeak);
    axiWrite(OFS_CTRL, {21'h0, 1'b1, minPeak[1], minPeak[0], 2'h0, act, 1'b0, m});
  endtask

  task automatic expectRelay(input logic e, input string what);
    repeat (4) @(posedge mclk);
    `CHK(what, e, relayOut)
    `CHK(what, e, ledOut)
  endtask

  task automatic testRegisters();
    axiRead(OFS_CTRL);
    `CHK("ctrl reset", CTRL_RST, rd)
    `CHK("read resp", RESP_OKAY, rs)
    axiWrite(OFS_LINK_TO, 32'h0000_1234);
    `CHK("write resp", RESP_OKAY, rs)
    wstrb <= 4'h2;
    axiWrite(OFS_LINK_TO, 32'h0000_abcd);
    wstrb <= 4'hf;
    axiRead(OFS_LINK_TO);
    `CHK("byte strobe", 32'h0000_ab34, rd)
    axiRead(8'h20);
    `CHK("unmapped read", RESP_SLVERR, rs)
    axiWrite(8'h24, 32'h1);
    `CHK("unmapped write", RESP_SLVERR, rs)
    axiWrite(OFS_THR_ONE, 32'h0000_8000);
    axiRead(OFS_THR_ONE);
    `CHK("thr clamp", 32'hffff_fc19, rd)
    axiWrite(OFS_HYSTERESIS_HALF_WIDTH, 32'd2000);
    axiRead(OFS_HYSTERESIS_HALF_WIDTH);
    `CHK("hysteresis_half_width clamp", 32'h0000_03e7, rd)
  endtask

  task automatic testSingle();
    axiWrite(OFS_THR_ONE, 32'd100);
    axiWrite(OFS_HYSTERESIS_HALF_WIDTH, 32'd10);
    ctrl(MODE_NORMAL, ACT_HOLD, 2'b00);
    src_u.setValue(16'sd111);
    expectRelay(1'b1, "normal on");
    src_u.setValue(16'sd95);
    expectRelay(1'b1, "normal band");
    src_u.setValue(16'sd89);
    expectRelay(1'b0, "normal off");
    ctrl(MODE_INVERTED, ACT_HOLD, 2'b00);
    expectRelay(1'b1, "inverted low");
    src_u.setValue(16'sd111);
    expectRelay(1'b0, "inverted high");
    ctrl(MODE_NORMAL, ACT_HOLD, 2'b10);
    src_u.setValue(16'sd0);
    src_u.setPeak(1'b1, 16'sd200);
    expectRelay(1'b1, "peak source");
    src_u.setPeak(1'b0, 16'sd200);
    expectRelay(1'b0, "peak idle");
    src_u.setValue(16'sd120);
    expectRelay(1'b1, "before fault");
    src_u.setFault(1'b1);
    src_u.setValue(16'sd0);
    expectRelay(1'b1, "fault hold");
    ctrl(MODE_NORMAL, ACT_FORCE_OFF, 2'b00);
    expectRelay(1'b0, "fault off");
    ctrl(MODE_INACTIVE, ACT_FORCE_ON, 2'b00);
    expectRelay(1'b1, "inactive forced");
    src_u.setFault(1'b0);
    expectRelay(1'b0, "inactive");
  endtask

  task automatic testWindow();
    axiWrite(OFS_THR_ONE, 32'd200);
    axiWrite(OFS_THR_TWO, 32'd100);
    src_u.setValue(16'sd150);
    ctrl(MODE_INSIDE, ACT_HOLD, 2'b00);
    expectRelay(1'b1, "inside mid");
    src_u.setValue(16'sd250);
    expectRelay(1'b0, "inside high");
    ctrl(MODE_OUTSIDE, ACT_HOLD, 2'b00);
    expectRelay(1'b1, "outside high");
    src_u.setValue(16'sd150);
    expectRelay(1'b0, "outside mid");
    src_u.setValue(16'sd50);
    expectRelay(1'b1, "outside low");
    axiWrite(OFS_CTRL, {21'h0, 1'b0, 2'b00, 2'h0, ACT_HOLD, 1'b0, MODE_OUTSIDE});
    repeat (4) @(posedge mclk);
    `CHK("unfitted relay", 1'b0, relayOut)
    `CHK("unfitted led", 1'b1, ledOut)
  endtask

  task automatic testBus();
    axiWrite(OFS_LINK_TO, 32'd0);
    ctrl(MODE_BUS, ACT_HOLD, 2'b00);
    src_u.sendCmd(1'b0);
    src_u.setValue(16'sd150);
    expectRelay(1'b0, "bus ignores input");
    src_u.sendCmd(1'b1);
    expectRelay(1'b1, "bus on");
    src_u.sendCmd(1'b0);
    expectRelay(1'b0, "bus off");
    axiWrite(OFS_LINK_TO, 32'd2);
    ctrl(MODE_BUS, ACT_FORCE_ON, 2'b00);
    src_u.sendCmd(1'b0);
    src_u.sendCmd(1'b0);
    expectRelay(1'b0, "link fresh");
    repeat (30) @(posedge mclk);
    expectRelay(1'b1, "link silent");
    axiRead(OFS_STATUS);
    `CHK("status fault", 32'h0000_0003, rd)
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    expectRelay(1'b0, "reset after bus");
  endtask

  task automatic testDelays();
    axiWrite(OFS_THR_ONE, 32'd100);
    axiWrite(OFS_HYSTERESIS_HALF_WIDTH, 32'd10);
    axiWrite(OFS_ON_DLY, 32'd5);
    axiWrite(OFS_OFF_DLY, 32'd3);
    src_u.setValue(16'sd0);
    ctrl(MODE_NORMAL, ACT_HOLD, 2'b00);
    src_u.setValue(16'sd120);
    repeat (12) @(posedge mclk);
    src_u.setValue(16'sd0);
    src_u.setValue(16'sd120);
    repeat (12) @(posedge mclk);
    src_u.setValue(16'sd0);
    expectRelay(1'b0, "short excursion");
    src_u.setValue(16'sd120);
    repeat (10) @(posedge mclk);
    expectRelay(1'b0, "on delay running");
    repeat (16) @(posedge mclk);
    expectRelay(1'b1, "on delay done");
    src_u.setValue(16'sd0);
    expectRelay(1'b1, "off delay running");
    repeat (20) @(posedge mclk);
    expectRelay(1'b0, "off delay done");
    axiWrite(OFS_ON_DLY, 32'd1);
    ctrl(MODE_NORMAL, ACT_HOLD, 2'b01);
    src_u.setValue(16'sd120);
    repeat (150) @(posedge mclk);
    expectRelay(1'b0, "minute base running");
    repeat (200) @(posedge mclk);
    expectRelay(1'b1, "minute base done");
  endtask

  initial begin
    srst    = 1'b1;
    awaddr  = '0;
    araddr  = '0;
    wdata   = '0;
    wstrb   = 4'hf;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    testRegisters();
    testSingle();
    testWindow();
    testBus();
    testDelays();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_sim();
  end
endmodule
